//--- src/fbwm_params.svh
// Constants for the framebuffer write-mask and clear block.
// Assumes inclusion by bare name from any file that needs these values.
`ifndef FBWM_PARAMS_SVH
`define FBWM_PARAMS_SVH
`define FBWM_NUM_DRAW     4
`define FBWM_DRAW_IDX_W   3
`define FBWM_STENCIL_W    8
`define FBWM_DEPTH_FIX_W  24
// Register offsets (byte addresses on the plain port)
`define FBWM_OFS_CMD        8'h00
`define FBWM_OFS_CMD_ARG    8'h04
`define FBWM_OFS_CLR_R      8'h08
`define FBWM_OFS_CLR_G      8'h0c
`define FBWM_OFS_CLR_B      8'h10
`define FBWM_OFS_CLR_A      8'h14
`define FBWM_OFS_DEPTH_VAL  8'h18
`define FBWM_OFS_STEN_VAL   8'h1c
`define FBWM_OFS_STATUS     8'h20
`define FBWM_OFS_CMASKS     8'h24
`define FBWM_OFS_SMASKS     8'h28
`define FBWM_OFS_PRESENT    8'h2c
`define FBWM_OFS_DRAWSEL    8'h30
`define FBWM_OFS_DEPTH_FIX  8'h34
// Clear mask bit positions
`define FBWM_CLR_COLOR_BIT   0
`define FBWM_CLR_DEPTH_BIT   1
`define FBWM_CLR_STENCIL_BIT 2
// Reset values
`define FBWM_RST_CMASK      4'hf
`define FBWM_RST_SMASK      8'hff
`define FBWM_RST_DEPTH      32'h3f800000
`define FBWM_RST_ZERO32     32'h00000000
`define FBWM_FLT_ONE        32'h3f800000
`define FBWM_FLT_NEG_ONE    32'hbf800000
`endif

//--- src/fbwm_pkg.sv
// Types shared by the framebuffer write-mask and clear block.
// Assumes fbwm_params.svh is available on the include path.
`include "fbwm_params.svh"
package fbwm_pkg;
   // =========================================================
   // Commands written to the command register
   typedef enum logic [3:0] {
      CMD_NOP          = 4'h0,
      CMD_COLOR_MASK   = 4'h1, // per_buffer_color_mask_cmd
      CMD_COLOR_MASK_ALL = 4'h2,
      CMD_DEPTH_WE     = 4'h3, // depth_write_enable_cmd
      CMD_STEN_MASK    = 4'h4, // stencil_bit_mask_cmd
      CMD_STEN_FACE    = 4'h5, // stencil_face_mask_cmd
      CMD_SET_DEPTH    = 4'h6, // set_depth_clear_value
      CMD_SET_STENCIL  = 4'h7, // set_stencil_clear_value
      CMD_CLEAR        = 4'h8,
      CMD_CLR_COLOR_I  = 4'h9, // per_buffer_clear_cmd, colour
      CMD_CLR_DEPTH_I  = 4'ha, // per_buffer_clear_cmd, depth
      CMD_CLR_STEN_I   = 4'hb, // per_buffer_clear_cmd, stencil
      CMD_CLR_DS       = 4'hc  // depth_stencil_clear_cmd
   } fbwm_cmd_t;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ISSUE = 3'b010,
      ST_DONE  = 3'b100
   } fbwm_state_t;
   // One clear job handed to the raster write back end
   typedef struct packed {
      logic                          valid;
      logic [`FBWM_NUM_DRAW-1:0]     color_targets;
      logic                          depth;
      logic                          stencil;
      logic [3:0]                    color_we;
      logic [4*16-1:0]               color_unorm;
      logic [4*16-1:0]               color_snorm;
      logic [31:0]                   depth_float;
      logic [`FBWM_DEPTH_FIX_W-1:0]  depth_fixed;
      logic [`FBWM_STENCIL_W-1:0]    stencil_val;
      logic [`FBWM_STENCIL_W-1:0]    stencil_we;
   } fbwm_clear_t;
   // Fragment write request and its masked result
   typedef struct packed {
      logic                          valid;
      logic                          back_face;
      logic                          multisample;
      logic [`FBWM_DRAW_IDX_W-1:0]   slot;
   } fbwm_frag_t;
   typedef struct packed {
      logic                          valid;
      logic [3:0]                    color_we;
      logic [3:0]                    sample_color_we;
      logic                          depth_we;
      logic [`FBWM_STENCIL_W-1:0]    stencil_we;
   } fbwm_fmask_t;
endpackage : fbwm_pkg

//--- src/fbwm_clamp.sv
// Float clamp and normalised fixed-point conversion for clear values.
// Assumes IEEE single-precision input; pure combinational leaf.
`timescale 1ns/1ps
`include "fbwm_params.svh"
module fbwm_clamp (
   input  wire logic [31:0] i_val,
   input  wire logic        i_signed,
   output logic [31:0]      o_clamped,
   output logic [23:0]      o_fixed
);
   // =========================================================
   // Clamp
   logic        neg;
   logic        ge_one;
   logic [23:0] mant;
   logic [7:0]  expo;
   logic [47:0] prod;
   logic [7:0]  sh;
   always_comb begin
      neg    = i_val[31];
      ge_one = (i_val[30:23] >= 8'h7f);
      if (neg && !i_signed) begin
         o_clamped = `FBWM_RST_ZERO32;
      end else if (ge_one) begin
         o_clamped = neg ? `FBWM_FLT_NEG_ONE : `FBWM_FLT_ONE;
      end else begin
         o_clamped = i_val;
      end
      // Magnitude to 24-bit fraction; truncation trades half an LSB for area
      expo = o_clamped[30:23];
      mant = {1'b1, o_clamped[22:0]};
      prod = 48'h0;
      sh   = 8'h7e - expo;
      if (expo >= 8'h7f) begin
         o_fixed = 24'hffffff;
      end else if (expo == 8'h00 || sh > 8'h18) begin
         o_fixed = 24'h000000;
      end else begin
         prod    = {mant, 24'h000000} >> sh;
         o_fixed = prod[47:24];
      end
      if (i_signed) begin
         o_fixed = {o_clamped[31], 23'h0} ^ {1'b0, o_fixed[23:1]};
         if (o_clamped[31]) begin
            o_fixed = 24'((~{1'b0, o_fixed[22:0]}) + 24'h1);
         end
      end
   end
endmodule : fbwm_clamp

//--- src/fbwm_top.sv
// Framebuffer write-mask state, clear values and clear issue.
// Assumes host commands arrive in order on the plain register port.
// Function
// - Colour mask slot above max flags error
// - Reset enables all RGBA writes per buffer
// - Depth write enable follows non-zero control
// - Low stencil mask bits gate bit writes
// - Front/back masks; face selects; single writes both
// - Front face uses front, back uses back
// - Stencil clear always uses front mask
// - Reset: stencil masks ones, depth/colour enabled
// - Multisample: masks gate samples, not colour buffers
// - Clear mask selects colour, depth, stencil
// - Unknown clear mask bits flag error (only when idle; a clear while busy is ignored without error)
// - Colour clear value stored as floats
// - Depth clear clamped, fixed for fixed buffers
// - Stencil clear value truncated to planes
// - Clear applies only allowed ops plus masks (slot 0 colour mask for all targets, depth write enable not applied)
// - Clear to absent buffer does nothing
// - Normalised colour clear clamped before conversion
// - Reset clear values: zero, one, zero
// - Slot colour clear targets slot buffers
// - Slot depth clear uses slot zero, float
// - Slot stencil clear uses slot zero, integer
// - Depth-stencil clear acts as two clears
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "fbwm_params.svh"
module fbwm_top (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_sys_rst,
   input  wire logic [7:0]            i_addr,
   input  wire logic [31:0]           i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   input  wire fbwm_pkg::fbwm_frag_t  i_frag,
   input  wire logic                  i_clear_done,
   output logic [31:0]                o_rdata,
   output fbwm_pkg::fbwm_clear_t      o_clear,
   output fbwm_pkg::fbwm_fmask_t      o_fmask,
   output logic                       o_busy,
   output logic                       o_err_invalid
);
   localparam int ND = `FBWM_NUM_DRAW;
   localparam int SW = `FBWM_STENCIL_W;
   // =========================================================
   // State record
   typedef struct packed {
      fbwm_pkg::fbwm_state_t        st;
      logic [ND-1:0][3:0]           cmask;
      logic                         depth_we;
      logic [SW-1:0]                smask_front;
      logic [SW-1:0]                smask_back;
      logic [3:0][31:0]             clr_color;
      logic [31:0]                  clr_depth;
      logic [SW-1:0]                clr_stencil;
      logic [31:0]                  arg;
      logic [3:0][31:0]             op_color;
      logic [31:0]                  op_depth;
      logic [SW-1:0]                op_stencil;
      logic [2:0]                   present;
      logic [ND-1:0][ND-1:0]        drawsel;
      logic                         err;
      logic                         busy;
      logic [31:0]                  rdata;
      fbwm_pkg::fbwm_clear_t        clear;
      fbwm_pkg::fbwm_fmask_t        fmask;
   } fbwm_top_state_t;
   fbwm_top_state_t s_r;
   fbwm_top_state_t s_nxt;
   // =========================================================
   // Helpers
   function automatic logic [SW-1:0] trunc_sten(input logic [31:0] v);
      trunc_sten = v[SW-1:0];
   endfunction : trunc_sten
   function automatic logic slot_ok(input logic [31:0] v);
      slot_ok = (v < 32'(ND));
   endfunction : slot_ok
   // Clear value clamps
   logic [3:0][31:0] col_cl;
   logic [3:0][23:0] col_un;
   logic [3:0][23:0] col_sn;
   logic [31:0]      dep_cl;
   logic [23:0]      dep_fx;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_col
         fbwm_clamp u_un (
            .i_val     (s_r.op_color[gi]),
            .i_signed  (1'b0),
            .o_clamped (col_cl[gi]),
            .o_fixed   (col_un[gi])
         );
         fbwm_clamp u_sn (
            .i_val     (s_r.op_color[gi]),
            .i_signed  (1'b1),
            .o_clamped (),
            .o_fixed   (col_sn[gi])
         );
      end
   endgenerate
   fbwm_clamp u_dep (
      .i_val     (s_r.arg),
      .i_signed  (1'b0),
      .o_clamped (dep_cl),
      .o_fixed   ()
   );
   fbwm_clamp u_dfx (
      .i_val     (s_r.op_depth),
      .i_signed  (1'b0),
      .o_clamped (),
      .o_fixed   (dep_fx)
   );
   // =========================================================
   // Next state
   fbwm_pkg::fbwm_cmd_t cmd;
   logic [ND-1:0]       targets;
   always_comb begin
      s_nxt   = s_r;
      cmd     = fbwm_pkg::fbwm_cmd_t'(i_wdata[3:0]);
      targets = '0;
      s_nxt.err = 1'b0;
      // Fragment mask path, one cycle through
      s_nxt.fmask.valid = i_frag.valid;
      s_nxt.fmask.depth_we = s_r.depth_we;
      s_nxt.fmask.stencil_we = i_frag.back_face ? s_r.smask_back
                                                 : s_r.smask_front;
      if (slot_ok({29'h0, i_frag.slot})) begin
         s_nxt.fmask.sample_color_we = s_r.cmask[i_frag.slot[1:0]];
      end else begin
         s_nxt.fmask.sample_color_we = 4'h0;
      end
      // Colour buffers take the combined samples
      s_nxt.fmask.color_we = i_frag.multisample ? 4'hf
                                                : s_nxt.fmask.sample_color_we;
      // Register reads answer one cycle later
      s_nxt.rdata = 32'h0;
      if (i_rd) begin
         unique case (i_addr)
            `FBWM_OFS_CMD_ARG:   s_nxt.rdata = s_r.arg;
            `FBWM_OFS_CLR_R:     s_nxt.rdata = s_r.clr_color[0];
            `FBWM_OFS_CLR_G:     s_nxt.rdata = s_r.clr_color[1];
            `FBWM_OFS_CLR_B:     s_nxt.rdata = s_r.clr_color[2];
            `FBWM_OFS_CLR_A:     s_nxt.rdata = s_r.clr_color[3];
            `FBWM_OFS_DEPTH_VAL: s_nxt.rdata = s_r.clr_depth;
            `FBWM_OFS_STEN_VAL:  s_nxt.rdata = 32'(s_r.clr_stencil);
            `FBWM_OFS_STATUS:    s_nxt.rdata = {29'h0, s_r.depth_we, s_r.busy, s_r.st[0]};
            `FBWM_OFS_CMASKS:    s_nxt.rdata = 32'(s_r.cmask);
            `FBWM_OFS_SMASKS:    s_nxt.rdata = {16'h0, s_r.smask_back, s_r.smask_front};
            `FBWM_OFS_PRESENT:   s_nxt.rdata = {29'h0, s_r.present};
            `FBWM_OFS_DRAWSEL:   s_nxt.rdata = 32'(s_r.drawsel);
            `FBWM_OFS_DEPTH_FIX: s_nxt.rdata = 32'(dep_fx);
            default:             s_nxt.rdata = 32'h0;
         endcase
      end
      // Register writes
      if (i_wr) begin
         unique case (i_addr)
            `FBWM_OFS_CMD_ARG:   s_nxt.arg = i_wdata;
            `FBWM_OFS_CLR_R:     s_nxt.clr_color[0] = i_wdata;
            `FBWM_OFS_CLR_G:     s_nxt.clr_color[1] = i_wdata;
            `FBWM_OFS_CLR_B:     s_nxt.clr_color[2] = i_wdata;
            `FBWM_OFS_CLR_A:     s_nxt.clr_color[3] = i_wdata;
            `FBWM_OFS_PRESENT:   s_nxt.present = i_wdata[2:0];
            `FBWM_OFS_DRAWSEL:   s_nxt.drawsel = i_wdata[ND*ND-1:0];
            `FBWM_OFS_CMD: begin
               unique case (cmd)
                  fbwm_pkg::CMD_COLOR_MASK: begin
                     if (slot_ok(s_r.arg)) begin
                        s_nxt.cmask[s_r.arg[1:0]] = i_wdata[7:4];
                     end else begin
                        s_nxt.err = 1'b1;
                     end
                  end
                  fbwm_pkg::CMD_COLOR_MASK_ALL: begin
                     for (int k = 0; k < ND; k++) begin
                        s_nxt.cmask[k] = i_wdata[7:4];
                     end
                  end
                  fbwm_pkg::CMD_DEPTH_WE: s_nxt.depth_we = (s_r.arg != 32'h0);
                  fbwm_pkg::CMD_STEN_MASK: begin
                     s_nxt.smask_front = trunc_sten(s_r.arg);
                     s_nxt.smask_back  = trunc_sten(s_r.arg);
                  end
                  fbwm_pkg::CMD_STEN_FACE: begin
                     if (i_wdata[4]) s_nxt.smask_front = trunc_sten(s_r.arg);
                     if (i_wdata[5]) s_nxt.smask_back  = trunc_sten(s_r.arg);
                  end
                  fbwm_pkg::CMD_SET_DEPTH: s_nxt.clr_depth = dep_cl;
                  fbwm_pkg::CMD_SET_STENCIL: s_nxt.clr_stencil = trunc_sten(s_r.arg);
                  default: ;
               endcase
               // Clear family: operands frozen at issue
               if (s_r.st == fbwm_pkg::ST_IDLE) begin
                  s_nxt.op_color = s_r.clr_color;
                  s_nxt.op_depth = s_r.clr_depth;
                  s_nxt.op_stencil = s_r.clr_stencil;
                  s_nxt.clear.color_targets = '0;
                  s_nxt.clear.depth = 1'b0;
                  s_nxt.clear.stencil = 1'b0;
                  unique case (cmd)
                     fbwm_pkg::CMD_CLEAR: begin
                        if (s_r.arg[31:3] != 29'h0) begin
                           s_nxt.err = 1'b1;
                        end else begin
                           for (int k = 0; k < ND; k++) begin
                              targets = targets | s_r.drawsel[k];
                           end
                           if (s_r.arg[`FBWM_CLR_COLOR_BIT]) begin
                              s_nxt.clear.color_targets = targets;
                           end
                           s_nxt.clear.depth   = s_r.arg[`FBWM_CLR_DEPTH_BIT];
                           s_nxt.clear.stencil = s_r.arg[`FBWM_CLR_STENCIL_BIT];
                        end
                     end
                     fbwm_pkg::CMD_CLR_COLOR_I: begin
                        if (slot_ok(s_r.arg)) begin
                           s_nxt.clear.color_targets = s_r.drawsel[s_r.arg[1:0]];
                        end else begin
                           s_nxt.err = 1'b1;
                        end
                     end
                     fbwm_pkg::CMD_CLR_DEPTH_I: begin
                        s_nxt.clear.depth = (s_r.arg == 32'h0);
                        s_nxt.err = (s_r.arg != 32'h0);
                     end
                     fbwm_pkg::CMD_CLR_STEN_I: begin
                        s_nxt.clear.stencil = (s_r.arg == 32'h0);
                        s_nxt.err = (s_r.arg != 32'h0);
                     end
                     fbwm_pkg::CMD_CLR_DS: begin
                        s_nxt.clear.depth   = (s_r.arg == 32'h0);
                        s_nxt.clear.stencil = (s_r.arg == 32'h0);
                        s_nxt.err = (s_r.arg != 32'h0);
                     end
                     default: ;
                  endcase
                  // Absent buffers are dropped from the job
                  if (!s_r.present[`FBWM_CLR_COLOR_BIT]) s_nxt.clear.color_targets = '0;
                  if (!s_r.present[`FBWM_CLR_DEPTH_BIT]) s_nxt.clear.depth = 1'b0;
                  if (!s_r.present[`FBWM_CLR_STENCIL_BIT]) s_nxt.clear.stencil = 1'b0;
                  if (s_nxt.clear.color_targets != '0 || s_nxt.clear.depth
                      || s_nxt.clear.stencil) begin
                     s_nxt.st = fbwm_pkg::ST_ISSUE;
                     s_nxt.busy = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end
      // Clear issue sequencer
      unique case (s_r.st)
         fbwm_pkg::ST_IDLE: s_nxt.clear.valid = 1'b0;
         fbwm_pkg::ST_ISSUE: begin
            s_nxt.clear.valid = 1'b1;
            s_nxt.clear.color_we = s_r.cmask[0];
            s_nxt.clear.stencil_we = s_r.smask_front;
            s_nxt.clear.depth_float = s_r.op_depth;
            s_nxt.clear.depth_fixed = dep_fx;
            s_nxt.clear.stencil_val = s_r.op_stencil;
            for (int k = 0; k < 4; k++) begin
               s_nxt.clear.color_unorm[k*16 +: 16] = col_un[k][23:8];
               s_nxt.clear.color_snorm[k*16 +: 16] = col_sn[k][23:8];
            end
            s_nxt.st = fbwm_pkg::ST_DONE;
         end
         fbwm_pkg::ST_DONE: begin
            if (i_clear_done) begin
               s_nxt.clear.valid = 1'b0;
               s_nxt.busy = 1'b0;
               s_nxt.st = fbwm_pkg::ST_IDLE;
            end
         end
         default: s_nxt.st = fbwm_pkg::ST_IDLE;
      endcase
   end
   // =========================================================
   // Registers
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         s_r             <= '0;
         s_r.st          <= fbwm_pkg::ST_IDLE;
         s_r.cmask       <= {ND{`FBWM_RST_CMASK}};
         s_r.depth_we    <= 1'b1;
         s_r.smask_front <= `FBWM_RST_SMASK;
         s_r.smask_back  <= `FBWM_RST_SMASK;
         s_r.clr_color   <= {4{`FBWM_RST_ZERO32}};
         s_r.clr_depth   <= `FBWM_RST_DEPTH;
         s_r.present     <= 3'h7;
         s_r.drawsel     <= {{(ND*ND-1){1'b0}}, 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign o_rdata       = s_r.rdata;
   assign o_clear       = s_r.clear;
   assign o_fmask       = s_r.fmask;
   assign o_busy        = s_r.busy;
   assign o_err_invalid = s_r.err;
endmodule : fbwm_top

//--- verification/fbwm_asserts.sv
// ====================================================
// Checker for the write-mask and clear block, bound to fbwm_top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module fbwm_asserts (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_sys_rst,
   input  wire logic [7:0]            i_addr,
   input  wire logic [31:0]           i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   input  wire fbwm_pkg::fbwm_frag_t  i_frag,
   input  wire logic                  i_clear_done,
   input  wire logic [31:0]           o_rdata,
   input  wire fbwm_pkg::fbwm_clear_t o_clear,
   input  wire fbwm_pkg::fbwm_fmask_t o_fmask,
   input  wire logic                  o_busy,
   input  wire logic                  o_err_invalid
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   // Shadow of the mask state, rebuilt from the command writes
   logic [31:0] arg_r;
   logic [7:0]  front_r;
   logic [7:0]  back_r;
   logic        dwe_r;
   wire         cmd  = i_wr && i_addr == 8'h00;
   wire         face = cmd && i_wdata[3:0] == 4'h5;
   wire         both = cmd && i_wdata[3:0] == 4'h4;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         arg_r   <= 32'h0;
         front_r <= 8'hff;
         back_r  <= 8'hff;
         dwe_r   <= 1'b1;
      end else begin
         if (i_wr && i_addr == 8'h04) arg_r <= i_wdata;
         if (cmd && i_wdata[3:0] == 4'h3) dwe_r <= arg_r != 32'h0;
         if (both || (face && i_wdata[4])) front_r <= arg_r[7:0];
         if (both || (face && i_wdata[5])) back_r <= arg_r[7:0];
      end
   end
   property p_mask_err;
      cmd && i_wdata[3:0] == 4'h1 && arg_r > 32'h3 |=> o_err_invalid;
   endproperty
   a_mask_err: assert property (p_mask_err) else $error("slot mask error missing");
   property p_clr_err;
      cmd && i_wdata[3:0] == 4'h8 && arg_r[31:3] != 0 && !o_busy |=> o_err_invalid;
   endproperty
   a_clr_err: assert property (p_clr_err) else $error("clear mask error missing");
   property p_depth_we;
      i_frag.valid |=> o_fmask.depth_we == $past(dwe_r);
   endproperty
   a_depth_we: assert property (p_depth_we) else $error("depth enable wrong");
   property p_face;
      i_frag.valid |=> o_fmask.stencil_we ==
         ($past(i_frag.back_face) ? $past(back_r) : $past(front_r));
   endproperty
   a_face: assert property (p_face) else $error("stencil face mask wrong");
   property p_ms;
      i_frag.valid && i_frag.multisample |=> o_fmask.valid && o_fmask.color_we == 4'hf;
   endproperty
   a_ms: assert property (p_ms) else $error("multisample colour gate wrong");
   property p_clr_front;
      $rose(o_clear.valid) && o_clear.stencil |-> o_clear.stencil_we == $past(front_r);
   endproperty
   a_clr_front: assert property (p_clr_front) else $error("clear not front mask");
   property p_issue;
      cmd && i_wdata[3:0] == 4'h8 && arg_r[2:0] != 0 && arg_r[31:3] == 0 && !o_busy
         |-> ##[1:4] o_clear.valid;
   endproperty
   a_issue: assert property (p_issue) else $error("clear job not issued");
   property p_finish;
      o_clear.valid && i_clear_done |=> !o_clear.valid && !o_busy;
   endproperty
   a_finish: assert property (p_finish) else $error("clear job not retired");
   property p_dclamp;
      o_clear.valid && o_clear.depth |-> o_clear.depth_float <= 32'h3f800000;
   endproperty
   a_dclamp: assert property (p_dclamp) else $error("depth clear not clamped");
endmodule : fbwm_asserts
bind fbwm_top fbwm_asserts fbwm_asserts_inst (.*);

//--- verification/fbwm_backend_model.sv
// ====================================================
// Raster back end that executes clear jobs, fast or slow.
// Assumes the job stays valid until the cycle after done.
`timescale 1ns/1ps
module fbwm_backend_model (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_slow,
   input  wire fbwm_pkg::fbwm_clear_t i_clear,
   output logic                       o_done
);
   logic [3:0] cnt_r;
   logic       hold_r;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         cnt_r  <= 4'h0;
         hold_r <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         // Wait for the finished job to drop so it is not counted twice
         if (o_done || hold_r) begin
            hold_r <= i_clear.valid;
         end else if (i_clear.valid) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == (i_slow ? 4'h9 : 4'h1)) begin
               cnt_r  <= 4'h0;
               o_done <= 1'b1;
            end
         end
      end
   end
endmodule : fbwm_backend_model

//--- verification/tb_top.sv
// ====================================================
// Self-checking bench for fbwm_top with a back-end model.
// Assumes the plain register port and the command offsets of the header.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic                  clk_sys = 1'b0;
   logic                  sys_rst = 1'b1;
   logic [7:0]            addr    = 8'h00;
   logic [31:0]           wdata   = 32'h0;
   logic                  wr_s    = 1'b0;
   logic                  rd_s    = 1'b0;
   logic                  slow    = 1'b0;
   fbwm_pkg::fbwm_frag_t  frag    = '0;
   fbwm_pkg::fbwm_clear_t clr;
   fbwm_pkg::fbwm_fmask_t fm;
   logic [31:0]           rdata, rv, a;
   logic                  done, busy, err, err_s, dwe;
   logic [3:0]            cm [4];
   logic [7:0]            fr, bk;
   logic [31:0]           dv [3] = '{32'h40000006, 32'hc0400006, 32'h3e800006};
   int                    fail_count = 0;
   int                    n_tests = 0;
   integer                seed = 32'hb0dc510c;
   fbwm_top fbwm_top_inst (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .i_frag(frag), .i_clear_done(done),
      .o_rdata(rdata), .o_clear(clr), .o_fmask(fm), .o_busy(busy), .o_err_invalid(err));
   fbwm_backend_model fbwm_backend_model_inst (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst),
      .i_slow(slow), .i_clear(clr), .o_done(done));
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] clampd(input logic [31:0] x);
      return x[31] ? 32'h0 : (x > 32'h3f800000 ? 32'h3f800000 : x);
   endfunction : clampd
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk_sys);
      addr  <= ad;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk_sys);
      wr_s  <= 1'b0;
      @(negedge clk_sys);
      err_s = err;
   endtask : wr
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= ad;
      rd_s <= 1'b1;
      @(posedge clk_sys);
      rd_s <= 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask : rd
   task automatic cmd(input logic [3:0] op, input logic [31:0] arg, input logic [3:0] dat);
      wr(8'h04, arg);
      wr(8'h00, {24'h0, dat, op});
   endtask : cmd
   task automatic frg(input logic bf, input logic ms, input logic [2:0] sl);
      @(posedge clk_sys);
      frag <= {1'b1, bf, ms, sl};
      @(posedge clk_sys);
      frag <= '0;
      @(negedge clk_sys);
      `CHK(fm.stencil_we, bf ? bk : fr)
      `CHK(fm.color_we, ms ? 4'hf : cm[sl])
      `CHK(fm.sample_color_we, cm[sl])
      `CHK(fm.depth_we, dwe)
   endtask : frg
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   initial begin
      #(5 * 20000);
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      cm  = '{4'hf, 4'hf, 4'hf, 4'hf};
      fr  = 8'hff;
      bk  = 8'hff;
      dwe = 1'b1;
      rd(8'h24, rv);
      `CHK(rv, 32'h0000ffff)
      rd(8'h28, rv);
      `CHK(rv, 32'h0000ffff)
      rd(8'h18, rv);
      `CHK(rv, 32'h3f800000)
      for (int i = 0; i < 5; i++) begin
         rd(i < 4 ? 8'h08 + 8'(4 * i) : 8'h1c, rv);
         `CHK(rv, 32'h0)
      end
      $display("reset state test done");
      a = $random(seed);
      cmd(4'h2, 32'h0, a[3:0]);
      cm = '{4{a[3:0]}};
      for (int s = 0; s < 5; s++) begin
         a = $random(seed);
         cmd(4'h1, s, a[3:0]);
         `CHK(err_s, 1'(s > 3))
         if (s < 4) cm[s] = a[3:0];
         rd(8'h24, rv);
         `CHK(rv, {16'h0, cm[3], cm[2], cm[1], cm[0]})
      end
      $display("colour mask test done");
      a = $random(seed);
      cmd(4'h4, a | 32'hff00, 4'h0);
      fr = a[7:0];
      bk = a[7:0];
      for (int f = 1; f < 4; f++) begin
         a = $random(seed);
         cmd(4'h5, a, 4'(f));
         if (f[0]) fr = a[7:0];
         if (f[1]) bk = a[7:0];
         rd(8'h28, rv);
         `CHK(rv, {16'h0, bk, fr})
      end
      wr(8'h0c, a);
      rd(8'h0c, rv);
      `CHK(rv, a)
      $display("stencil mask test done");
      for (int i = 0; i < 12; i++) begin
         a = $random(seed);
         if (i == 4 || i == 8) cmd(4'h3, i == 4 ? 32'h0 : 32'h100, 4'h0);
         if (i == 4 || i == 8) dwe = i == 8;
         frg(a[0], a[1], {1'b0, a[3:2]});
      end
      $display("fragment mask test done");
      cmd(4'h7, 32'h1ab, 4'h0);
      rd(8'h1c, rv);
      `CHK(rv, 32'hab)
      cmd(4'h8, 32'h8, 4'h0);
      `CHK(err_s, 1'b1)
      foreach (dv[i]) begin
         cmd(4'h6, dv[i], 4'h0);
         rd(8'h18, rv);
         `CHK(rv, clampd(dv[i]))
      end
      slow <= 1'b1;
      cmd(4'h8, 32'h7, 4'h0);
      `CHK(err_s, 1'b0)
      for (int n = 0; n < 20 && clr.valid !== 1'b1; n++) @(negedge clk_sys);
      `CHK({clr.valid, clr.depth, clr.stencil, clr.color_we}, {3'b111, cm[0]})
      `CHK(clr.stencil_we, fr)
      `CHK(clr.stencil_val, 8'hab)
      `CHK(clr.depth_float, clampd(dv[2]))
      `CHK(clr.depth_fixed, 24'h400003)
      `CHK(clr.color_targets, 4'h1)
      cmd(4'h8, 32'h9, 4'h0);
      `CHK(err_s, 1'b0)
      for (int n = 0; n < 40 && busy !== 1'b0; n++) @(negedge clk_sys);
      `CHK({busy, clr.valid}, 2'b00)
      for (int op = 9; op < 13; op++) begin
         cmd(4'(op), 32'h4, 4'h0);
         `CHK(err_s, 1'b1)
      end
      $display("clear test done");
      close_out();
   end
endmodule : tb_top
